/* File: hw/rf_link_mode_config.sv */
// General, transmit and receive mode registers of the framing core and
// the small pieces of logic they steer directly.
// Assumes one clock, inputs synchronous to it, and a simple register port.
`timescale 1ns/1ps
`include "rf_link_params.svh"

module rf_link_mode_config #(
    parameter int CNT_W = 8
) (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire rf_link_pkg::reg_req_t reg_req,
    output logic [7:0] rd_data,
    input wire logic rf_busy,
    input wire logic [15:0] checksum_raw,
    output logic [7:0] checksum_result_high,
    output logic [7:0] checksum_result_low,
    output logic checksum_high_bit_first,
    output logic [15:0] checksum_init,
    input wire logic field_on,
    input wire logic tx_start_req,
    output logic tx_start,
    output logic tx_start_refused,
    input wire logic aux_envelope_input,
    output logic envelope_n,
    output logic aux_input_active_event,
    output logic tx_checksum_enable,
    output logic [2:0] tx_bit_rate_select,
    input wire logic tx_data,
    output logic tx_mod_out,
    output logic rx_checksum_enable,
    output logic [2:0] rx_bit_rate_select,
    output logic rx_multi_frame,
    input wire logic rx_start,
    input wire logic cmd_write,
    input wire logic cmd_is_receive,
    input wire logic rx_stream_end,
    input wire logic [CNT_W-1:0] rx_bit_count,
    output logic rx_active,
    output logic rx_frame_done,
    output logic rx_short_discard,
    input wire logic [7:0] error_flags,
    output logic fifo_wr,
    output logic [7:0] fifo_data
);
    import rf_link_pkg::*;

    logic [7:0] gen_q;
    logic [7:0] tx_q;
    logic [7:0] rx_q;
    logic [7:0] gen_d;
    logic [7:0] tx_d;
    logic [7:0] rx_d;
    logic wr_gen;
    logic wr_tx;
    logic wr_rx;
    logic hi_first;
    logic [15:0] preset_d;
    logic short_stream;
    rx_state_t rx_state_q;

    // Write decode for the three mode registers.
    assign wr_gen = reg_req.wr && (reg_req.addr == `ADDR_GEN_MODE);
    assign wr_tx = reg_req.wr && (reg_req.addr == `ADDR_TX_MODE);
    assign wr_rx = reg_req.wr && (reg_req.addr == `ADDR_RX_MODE);

    // Merge written bits with reserved reset bits; enables stay set above 106 kBd.
    always_comb begin
        gen_d = (reg_req.wdata & `GEN_WR_MASK) | (`RST_GEN_MODE & ~`GEN_WR_MASK);
        tx_d = (reg_req.wdata & `TX_WR_MASK) | (`RST_TX_MODE & ~`TX_WR_MASK);
        rx_d = (reg_req.wdata & `RX_WR_MASK) | (`RST_RX_MODE & ~`RX_WR_MASK);
        if (tx_d[`RATE_HI:`RATE_LO] != `RATE_106) begin
            tx_d[`BIT_CRC_EN] = 1'b1;
        end
        if (rx_d[`RATE_HI:`RATE_LO] != `RATE_106) begin
            rx_d[`BIT_CRC_EN] = 1'b1;
        end
    end

    // General mode register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            gen_q <= `RST_GEN_MODE;
        end else if (wr_gen) begin
            gen_q <= gen_d;
        end
    end

    // Transmit mode register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_q <= `RST_TX_MODE;
        end else if (wr_tx) begin
            tx_q <= tx_d;
        end
    end

    // Receive mode register.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_q <= `RST_RX_MODE;
        end else if (wr_rx) begin
            rx_q <= rx_d;
        end
    end

    // Read data stand one cycle after the strobe; other addresses read zero.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rd_data <= 8'h00;
        end else if (reg_req.rd) begin
            case (reg_req.addr)
                `ADDR_GEN_MODE: rd_data <= gen_q;
                `ADDR_TX_MODE: rd_data <= tx_q;
                `ADDR_RX_MODE: rd_data <= rx_q;
                default: rd_data <= 8'h00;
            endcase
        end else begin
            rd_data <= 8'h00;
        end
    end

    // Field decode straight from the stored bits.
    assign tx_checksum_enable = tx_q[`BIT_CRC_EN];
    assign rx_checksum_enable = rx_q[`BIT_CRC_EN];
    assign tx_bit_rate_select = tx_q[`RATE_HI:`RATE_LO];
    assign rx_bit_rate_select = rx_q[`RATE_HI:`RATE_LO];
    assign rx_multi_frame = rx_q[`BIT_MULTI];

    // Bit order only applies to the standalone checksum command.
    assign hi_first = gen_q[`BIT_HIGH_FIRST] && !rf_busy;
    assign checksum_high_bit_first = hi_first;

    // Result bytes, bit reversed when the high bit goes first.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            checksum_result_high <= 8'h00;
            checksum_result_low <= 8'h00;
        end else if (hi_first) begin
            checksum_result_high <= {<<{checksum_raw[15:8]}};
            checksum_result_low <= {<<{checksum_raw[7:0]}};
        end else begin
            checksum_result_high <= checksum_raw[15:8];
            checksum_result_low <= checksum_raw[7:0];
        end
    end

    // Preset: field for the command; during RF traffic PRESET_01 if either checksum enable is set, else PRESET_00.
    always_comb begin
        case (gen_q[`PRESET_HI:`PRESET_LO])
            2'b00: preset_d = `PRESET_00;
            2'b01: preset_d = `PRESET_01;
            2'b10: preset_d = `PRESET_10;
            default: preset_d = `PRESET_11;
        endcase
        if (rf_busy) begin
            preset_d = (tx_q[`BIT_CRC_EN] || rx_q[`BIT_CRC_EN]) ? `PRESET_01 : `PRESET_00;
        end
    end

    // Registered preset toward the checksum engine.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            checksum_init <= `PRESET_00;
        end else begin
            checksum_init <= preset_d;
        end
    end

    // Transmitter start gate on the field when waiting is asked for.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_start <= 1'b0;
            tx_start_refused <= 1'b0;
        end else begin
            tx_start <= tx_start_req && (!gen_q[`BIT_WAIT_FIELD] || field_on);
            tx_start_refused <= tx_start_req && gen_q[`BIT_WAIT_FIELD] && !field_on;
        end
    end

    // Envelope is held active low inside; pin level per polarity bit.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            envelope_n <= 1'b1;
        end else begin
            envelope_n <= gen_q[`BIT_AUX_POL] ? !aux_envelope_input : aux_envelope_input;
        end
    end

    // Any change of the polarity bit raises a one-cycle event.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            aux_input_active_event <= 1'b0;
        end else begin
            aux_input_active_event <= wr_gen && (gen_d[`BIT_AUX_POL] != gen_q[`BIT_AUX_POL]);
        end
    end

    // Modulation toward the driver, optionally inverted.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            tx_mod_out <= 1'b0;
        end else begin
            tx_mod_out <= tx_data ^ tx_q[`BIT_INV_MOD];
        end
    end

    // Streams below the minimum length count as short.
    assign short_stream = rx_stream_end && (rx_bit_count < CNT_W'(`MIN_STREAM_BITS));

    // Receiver state: one frame, or many until a non-receive command or bit clear.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_state_q <= RX_IDLE;
        end else begin
            case (rx_state_q)
                RX_IDLE: begin
                    if (rx_start) begin
                        rx_state_q <= RX_ACTIVE;
                    end
                end
                RX_ACTIVE: begin
                    if (cmd_write && !cmd_is_receive) begin
                        rx_state_q <= RX_IDLE;
                    end else if (wr_rx && !rx_d[`BIT_MULTI] && rx_q[`BIT_MULTI]) begin
                        rx_state_q <= RX_IDLE;
                    end else if (rx_stream_end && !(short_stream && rx_q[`BIT_SHORT_IGN])) begin
                        if (!rx_q[`BIT_MULTI]) begin
                            rx_state_q <= RX_IDLE;
                        end
                    end
                end
                default: rx_state_q <= RX_IDLE;
            endcase
        end
    end
    assign rx_active = (rx_state_q == RX_ACTIVE);

    // Stream end reports: a kept frame, or a discarded short one.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rx_frame_done <= 1'b0;
            rx_short_discard <= 1'b0;
        end else begin
            rx_frame_done <= rx_active && rx_stream_end
                && !(short_stream && rx_q[`BIT_SHORT_IGN]);
            rx_short_discard <= rx_active && short_stream && rx_q[`BIT_SHORT_IGN];
        end
    end

    // In multi-frame mode each kept stream is followed by an error byte.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            fifo_wr <= 1'b0;
            fifo_data <= 8'h00;
        end else begin
            fifo_wr <= rx_active && rx_stream_end && rx_q[`BIT_MULTI]
                && !(short_stream && rx_q[`BIT_SHORT_IGN]);
            if (rx_active && rx_stream_end) begin
                fifo_data <= error_flags;
            end
        end
    end

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);

    sequence s_gen_read;
        reg_req.rd && reg_req.addr == `ADDR_GEN_MODE;
    endsequence

    property p_reserved_read;
        s_gen_read |=> (rd_data & ~`GEN_WR_MASK) == (`RST_GEN_MODE & ~`GEN_WR_MASK);
    endproperty
    a_reserved_read: assert property (p_reserved_read)
        else $error("Reserved general mode bits read wrong.");

    property p_crc_stay;
        wr_tx && reg_req.wdata[`RATE_HI:`RATE_LO] != `RATE_106
            |=> tx_checksum_enable;
    endproperty
    a_crc_stay: assert property (p_crc_stay)
        else $error("Tx checksum cleared above 106 kBd.");

    property p_reverse;
        hi_first |=> checksum_result_high[7] == $past(checksum_raw[8]);
    endproperty
    a_reverse: assert property (p_reverse)
        else $error("Checksum high byte not reversed.");

    property p_order_busy;
        rf_busy |=> checksum_result_high == $past(checksum_raw[15:8])
            && checksum_result_low == $past(checksum_raw[7:0]);
    endproperty
    a_order_busy: assert property (p_order_busy)
        else $error("Bit order applied during RF traffic.");

    property p_wait_field;
        tx_start_req && gen_q[`BIT_WAIT_FIELD] && !field_on |=> !tx_start && tx_start_refused;
    endproperty
    a_wait_field: assert property (p_wait_field)
        else $error("Transmitter started without field.");

    property p_pol_event;
        wr_gen && reg_req.wdata[`BIT_AUX_POL] != gen_q[`BIT_AUX_POL]
            |=> aux_input_active_event ##1 !aux_input_active_event || $past(wr_gen);
    endproperty
    a_pol_event: assert property (p_pol_event)
        else $error("Polarity change raised no event.");

    property p_preset_11;
        !rf_busy && gen_q[`PRESET_HI:`PRESET_LO] == 2'b11 |=> checksum_init == `PRESET_11;
    endproperty
    a_preset_11: assert property (p_preset_11)
        else $error("Preset value wrong.");

    sequence s_short_end;
        rx_active && short_stream && rx_q[`BIT_SHORT_IGN] && !cmd_write && !wr_rx;
    endsequence

    property p_short_keep;
        s_short_end |=> rx_active && rx_short_discard && !fifo_wr;
    endproperty
    a_short_keep: assert property (p_short_keep)
        else $error("Short stream ended the receiver.");

    property p_multi_byte;
        rx_active && rx_stream_end && !short_stream && rx_q[`BIT_MULTI] && !cmd_write && !wr_rx
            |=> fifo_wr && fifo_data == $past(error_flags) && rx_active;
    endproperty
    a_multi_byte: assert property (p_multi_byte)
        else $error("Error byte missing in multi-frame mode.");

    property p_single_end;
        rx_active && rx_stream_end && !short_stream && !rx_q[`BIT_MULTI] |=> !rx_active;
    endproperty
    a_single_end: assert property (p_single_end)
        else $error("Receiver stayed on after one frame.");

    property p_invert;
        tx_q[`BIT_INV_MOD] |=> tx_mod_out == !$past(tx_data);
    endproperty
    a_invert: assert property (p_invert)
        else $error("Modulation not inverted.");
endmodule

/* File: pkg/rf_link_params.svh */
// Constants for the link mode register bank: offsets, reset values,
// write masks, bit positions, checksum presets and stream limits.
// Assumes inclusion by bare name from any file that needs them.
`ifndef RF_LINK_PARAMS_SVH
`define RF_LINK_PARAMS_SVH
`define ADDR_GEN_MODE 6'h11
`define ADDR_TX_MODE 6'h12
`define ADDR_RX_MODE 6'h13
`define RST_GEN_MODE 8'h3f
`define RST_TX_MODE 8'h00
`define RST_RX_MODE 8'h00
`define GEN_WR_MASK 8'hab
`define TX_WR_MASK 8'hf8
`define RX_WR_MASK 8'hfc
`define BIT_HIGH_FIRST 7
`define BIT_WAIT_FIELD 5
`define BIT_AUX_POL 3
`define BIT_CRC_EN 7
`define BIT_INV_MOD 3
`define BIT_SHORT_IGN 3
`define BIT_MULTI 2
`define RATE_HI 6
`define RATE_LO 4
`define PRESET_HI 1
`define PRESET_LO 0
`define RATE_106 3'h0
`define PRESET_00 16'h0000
`define PRESET_01 16'h6363
`define PRESET_10 16'ha671
`define PRESET_11 16'hffff
`define MIN_STREAM_BITS 8'h04
`endif

/* File: pkg/rf_link_pkg.sv */
// Types shared by the link mode register bank.
// Assumes a single clock domain and the constants header beside it.
package rf_link_pkg;
    typedef struct packed {
        logic [5:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_ACTIVE = 2'b01
    } rx_state_t;
endpackage

/* File: sim/card_model.sv */
// Behavioural card: after a receive request it answers with one data stream end.
// Assumes go is a one-cycle pulse driven just after a rising edge of clk_sys.
`timescale 1ns/1ps
module card_model (
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic go,
    input wire logic [7:0] bits,
    input wire logic [3:0] lag,
    output logic stream_end,
    output logic [7:0] bit_count
);
    logic [4:0] cnt_q;
    logic [7:0] bits_q;

    // Counts the reply lag, so the card answers promptly or slowly.
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= 5'h00;
            bits_q <= 8'h00;
        end else if (go) begin
            cnt_q <= {1'b0, lag} + 5'h01;
            bits_q <= bits;
        end else if (cnt_q != 5'h00) begin
            cnt_q <= cnt_q - 5'h01;
        end
    end

    // The count is only valid beside the end pulse; it churns while the lag counts down and holds the inverted bits when idle.
    assign stream_end = (cnt_q == 5'h01);
    assign bit_count = stream_end ? bits_q : (~bits_q ^ {3'h0, cnt_q});
endmodule

/* File: sim/testbench.sv */
// Self-checking bench for the link mode register bank with a card model.
// Assumes the constants header is on the include path.
`timescale 1ns/1ps
`include "rf_link_params.svh"
module testbench;
    import rf_link_pkg::*;
    reg_req_t req;
    logic clk_sys = 1'b0;
    logic arst_n, rf_busy, field_on, tx_req, aux_in, tx_data, rx_start, cmd_write, cmd_rcv, go;
    logic hbf, tx_start, refused, env_n, ev, txen, rxen, mod, multi, act, done, disc, fwr, send;
    logic [15:0] raw;
    logic [15:0] init;
    logic [7:0] eflags, bits, rd_data, res_h, res_l, fifo_data, cnt, gen_m, tx_m, rx_m, d, old;
    logic [3:0] lag;
    logic [2:0] txr, rxr;
    logic [7:0] corner [6] = '{8'ha8, 8'h30, 8'h0c, 8'h21, 8'h08, 8'h9c};
    int seed = 50;
    int failures = 0;
    int tests_run = 0;

    always #25 clk_sys = ~clk_sys;

    rf_link_mode_config dut_u (.clk_sys(clk_sys), .arst_n(arst_n), .reg_req(req),
        .rd_data(rd_data), .rf_busy(rf_busy), .checksum_raw(raw),
        .checksum_result_high(res_h), .checksum_result_low(res_l),
        .checksum_high_bit_first(hbf), .checksum_init(init), .field_on(field_on),
        .tx_start_req(tx_req), .tx_start(tx_start), .tx_start_refused(refused),
        .aux_envelope_input(aux_in), .envelope_n(env_n), .aux_input_active_event(ev),
        .tx_checksum_enable(txen), .tx_bit_rate_select(txr), .tx_data(tx_data),
        .tx_mod_out(mod), .rx_checksum_enable(rxen), .rx_bit_rate_select(rxr),
        .rx_multi_frame(multi), .rx_start(rx_start), .cmd_write(cmd_write),
        .cmd_is_receive(cmd_rcv), .rx_stream_end(send), .rx_bit_count(cnt),
        .rx_active(act), .rx_frame_done(done), .rx_short_discard(disc),
        .error_flags(eflags), .fifo_wr(fwr), .fifo_data(fifo_data));

    card_model card_u (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .bits(bits),
        .lag(lag), .stream_end(send), .bit_count(cnt));

    // Masks a transmit or receive write and forces the enable above 106 kBd.
    function automatic logic [7:0] rate_fix(input logic [7:0] w, input logic [7:0] m);
        logic [7:0] v;
        v = w & m;
        if (v[6:4] != `RATE_106) v[7] = 1'b1;
        return v;
    endfunction

    // Reverses the bit order of one byte, as the result bytes show it high-first.
    function automatic logic [7:0] rev8(input logic [7:0] v);
        logic [7:0] r;
        for (int b = 0; b < 8; b++) r[b] = v[7 - b];
        return r;
    endfunction

    // Picks the preset from the field, or automatically while RF traffic runs.
    function automatic logic [15:0] exp_init(input logic busy);
        if (busy) return (tx_m[7] | rx_m[7]) ? `PRESET_01 : `PRESET_00;
        case (gen_m[1:0])
            2'b00: return `PRESET_00;
            2'b01: return `PRESET_01;
            2'b10: return `PRESET_10;
            default: return `PRESET_11;
        endcase
    endfunction

    // Prints the verdict and stops the run.
    task automatic end_of_test();
        if (failures == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // Compares one observed value with its expectation.
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe; returns at the edge that takes it.
    task automatic wr_reg(input logic [5:0] a, input logic [7:0] w);
        req.addr <= a;
        req.wdata <= w;
        req.wr <= 1'b1;
        @(posedge clk_sys);
        req.wr <= 1'b0;
    endtask

    // One-cycle read strobe; the data is looked at in the following cycle.
    task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
        req.addr <= a;
        req.rd <= 1'b1;
        @(posedge clk_sys);
        req.rd <= 1'b0;
        @(negedge clk_sys);
        chk(rd_data, e);
        @(posedge clk_sys);
    endtask

    // Lets the card send one stream and checks how the receiver ends it.
    task automatic stream(input logic [7:0] n);
        logic sh;
        int k;
        sh = (n < `MIN_STREAM_BITS) && rx_m[`BIT_SHORT_IGN];
        eflags <= 8'($random(seed));
        bits <= n;
        lag <= 4'($random(seed));
        go <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        k = 0;
        while (done !== 1'b1 && disc !== 1'b1 && k < 40) begin
            @(negedge clk_sys);
            k++;
        end
        if (k == 40) begin
            failures++;
            end_of_test();
        end
        chk(disc, sh);
        chk(done, !sh);
        chk(fwr, !sh && rx_m[`BIT_MULTI]);
        if (!sh && rx_m[`BIT_MULTI]) chk(fifo_data, eflags);
        chk(act, sh || rx_m[`BIT_MULTI]);
        @(posedge clk_sys);
    endtask

    // Ends the receiver by a command; a receive command leaves it running.
    task automatic command(input logic rcv);
        cmd_write <= 1'b1;
        cmd_rcv <= rcv;
        @(posedge clk_sys);
        cmd_write <= 1'b0;
        @(negedge clk_sys);
        chk(act, rcv);
        @(posedge clk_sys);
    endtask

    initial begin
        req = '0;
        {arst_n, rf_busy, field_on, tx_req, aux_in, tx_data, rx_start, cmd_write} = '0;
        {cmd_rcv, go, raw, eflags, bits, lag} = '0;
        gen_m = `RST_GEN_MODE;
        tx_m = `RST_TX_MODE;
        rx_m = `RST_RX_MODE;
        repeat (12) @(posedge clk_sys);
        arst_n <= 1'b1;
        @(posedge clk_sys);
        rd_chk(`ADDR_GEN_MODE, 8'h3f);
        rd_chk(`ADDR_TX_MODE, 8'h00);
        rd_chk(`ADDR_RX_MODE, 8'h00);
        rd_chk(6'h10, 8'h00);
        // Random register writes with corner values first, each followed by a traffic cycle.
        for (int i = 0; i < 30; i++) begin
            d = (i < 6) ? corner[i] : 8'($random(seed));
            old = gen_m;
            if (i % 3 != 0) d[6] = 1'b0;
            wr_reg(6'h11 + 6'(i % 3), d);
            if (i % 3 == 0) gen_m = (d & `GEN_WR_MASK) | (`RST_GEN_MODE & ~`GEN_WR_MASK);
            if (i % 3 == 1) tx_m = rate_fix(d, `TX_WR_MASK);
            if (i % 3 == 2) rx_m = rate_fix(d, `RX_WR_MASK);
            @(negedge clk_sys);
            chk(ev, i % 3 == 0 && old[3] != d[3]);
            chk(txen, tx_m[7]);
            chk(rxen, rx_m[7]);
            chk(txr, tx_m[6:4]);
            chk(rxr, rx_m[6:4]);
            chk(multi, rx_m[`BIT_MULTI]);
            @(posedge clk_sys);
            rd_chk(6'h11 + 6'(i % 3), (i % 3 == 0) ? gen_m : (i % 3 == 1) ? tx_m : rx_m);
            {rf_busy, field_on, aux_in, tx_data} <= 4'($random(seed));
            raw <= 16'($random(seed));
            tx_req <= 1'b1;
            @(posedge clk_sys);
            tx_req <= 1'b0;
            @(negedge clk_sys);
            chk(hbf, gen_m[7] & !rf_busy);
            chk(res_h, (gen_m[7] & !rf_busy) ? rev8(raw[15:8]) : raw[15:8]);
            chk(res_l, (gen_m[7] & !rf_busy) ? rev8(raw[7:0]) : raw[7:0]);
            chk(init, exp_init(rf_busy));
            chk(mod, tx_data ^ tx_m[`BIT_INV_MOD]);
            chk(env_n, aux_in ^ gen_m[`BIT_AUX_POL]);
            chk(refused, gen_m[`BIT_WAIT_FIELD] & !field_on);
            chk(tx_start, !(gen_m[`BIT_WAIT_FIELD] & !field_on));
            @(posedge clk_sys);
        end
        command(1'b0);
        // Receive sequences: short ignored, multi-frame kept, command and bit clear ending.
        for (int j = 0; j < 3; j++) begin
            d = (j == 0) ? 8'h0c : (j == 1) ? 8'h00 : 8'h04;
            wr_reg(`ADDR_RX_MODE, d);
            rx_m = d;
            rx_start <= 1'b1;
            @(posedge clk_sys);
            rx_start <= 1'b0;
            @(negedge clk_sys);
            chk(act, 1'b1);
            @(posedge clk_sys);
            stream(8'h02);
            if (j != 1) stream(8'h09);
            if (j == 0) command(1'b1);
            if (j == 0) command(1'b0);
        end
        wr_reg(`ADDR_RX_MODE, 8'h00);
        rx_m = 8'h00;
        @(negedge clk_sys);
        chk(act, 1'b0);
        end_of_test();
    end
endmodule
